// *** logic/tics_axil_slave.v ***
`timescale 1ns/10ps
`default_nettype none
`include "tics_defines.vh"

// axi4-lite slave front end: one write and one read at a time
module tics_axil_slave (
   input wire aclk,
   input wire aresetn,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg wr_pulse,
   output reg [3:0] wr_addr,
   output reg [31:0] wr_data,
   output reg [3:0] wr_strb,
   output reg rd_pulse,
   output reg [3:0] rd_addr,
   input wire [31:0] rd_data,
   input wire rd_err,
   input wire wr_err
);

   reg aw_held;
   reg w_held;
   reg wr_wait;
   reg rd_wait;

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TICS_RESP_OKAY;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wr_wait <= 1'b0;
         wr_pulse <= 1'b0;
         wr_addr <= 4'h0;
         wr_data <= 32'h00000000;
         wr_strb <= 4'h0;
      end else begin
         wr_pulse <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         if (!aw_held && !wr_wait && s_axi_awvalid && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
         end
         if (!w_held && !wr_wait && s_axi_wvalid && !s_axi_wready) begin
            s_axi_wready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
         end
         if (aw_held && w_held && !wr_wait) begin
            wr_pulse <= 1'b1;
            wr_wait <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
         if (wr_pulse) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_err ? `TICS_RESP_SLVERR : `TICS_RESP_OKAY;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_wait <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `TICS_RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
         rd_wait <= 1'b0;
         rd_pulse <= 1'b0;
         rd_addr <= 4'h0;
      end else begin
         rd_pulse <= 1'b0;
         s_axi_arready <= 1'b0;
         if (!rd_wait && s_axi_arvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            rd_addr <= s_axi_araddr;
            rd_pulse <= 1'b1;
            rd_wait <= 1'b1;
         end
         if (rd_pulse) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_err ? `TICS_RESP_SLVERR : `TICS_RESP_OKAY;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_wait <= 1'b0;
         end
      end
   end

endmodule // tics_axil_slave
`default_nettype wire

// *** logic/tics_defines.vh ***
`ifndef TICS_DEFINES_VH
`define TICS_DEFINES_VH

// register byte addresses
`define TICS_ADDR_ENABLE 4'h0
`define TICS_ADDR_STATUS 4'h4
`define TICS_ADDR_CTRL 4'h8
`define TICS_ADDR_FIFO_RELEASE 4'hc

// field positions
`define TICS_BIT_WARN 9
`define TICS_BIT_UPDATE 8
`define TICS_QUEUE_LSB 0
`define TICS_QUEUES 4

// implemented bit mask of enable and status layout
`define TICS_FIELD_MASK 32'h0000030f
`define TICS_RESET_VALUE 32'h00000000

// control register bits (operation mode, stamp fifo on)
`define TICS_CTRL_OPER 0
`define TICS_CTRL_FIFO_ON 1
`define TICS_CTRL_MASK 32'h00000003

// axi responses
`define TICS_RESP_OKAY 2'b00
`define TICS_RESP_SLVERR 2'b10

`endif

// *** logic/tics_top.v ***
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "tics_defines.vh"

// Operation
// - warning enable plus warning flag raises interrupt
// - update enable plus update flag raises interrupt
// - queue enable and sent flag assert interrupt
// - reserved enable bits read zero
// - warning status bit shows warning pending
// - stamped frame with one entry sets warning
// - all enable fields reset to zero
// - warning flag cleared outside operation or fifo off
// - writing zero clears flag, one keeps it
// - queue sent flags set on frame, cleared leaving operation
// - update flag set on stamped frame, cleared by release
module tics_top (
   input wire aclk,
   input wire aresetn,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire stamp_frame_done,
   input wire stamp_fifo_one_entry,
   input wire [3:0] queue_frame_sent,
   output reg tx_irq
);

   wire wr_pulse;
   wire [3:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire rd_pulse;
   wire [3:0] rd_addr;
   reg [31:0] rd_data;
   reg rd_err;
   reg wr_err;

   reg [31:0] tx_interrupt_enable;
   reg [31:0] tx_interrupt_status;
   reg [31:0] ctrl;
   reg [31:0] next_status;
   reg oper_prev;
   reg stamp_fifo_release;

   wire oper_mode;
   wire stamp_fifo_on;
   wire stamp_fifo_warn_enable;
   wire stamp_fifo_update_enable;
   wire stamp_fifo_warn_flag;
   wire stamp_fifo_update_flag;
   wire [31:0] irq_src;
   wire queue0_sent_enable;
   wire queue1_sent_enable;
   wire queue2_sent_enable;
   wire queue3_sent_enable;
   wire queue0_sent_flag;
   wire queue1_sent_flag;
   wire queue2_sent_flag;
   wire queue3_sent_flag;

   // true when a write to the given address applies to byte lane of a bit
   function lane_hit;
      input [3:0] addr;
      input [3:0] want;
      input [3:0] strb;
      input [4:0] bitpos;
      begin
         lane_hit = (addr == want) && strb[bitpos[4:3]];
      end
   endfunction

   // expands the write strobes into a bit mask over the word
   function [31:0] byte_mask;
      input [3:0] strb;
      begin
         byte_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      end
   endfunction

   // mapped register check, used for both read and write answers
   function is_mapped;
      input [3:0] addr;
      begin
         is_mapped = (addr == `TICS_ADDR_ENABLE) || (addr == `TICS_ADDR_STATUS) ||
            (addr == `TICS_ADDR_CTRL) || (addr == `TICS_ADDR_FIFO_RELEASE);
      end
   endfunction

   tics_axil_slave u_slave (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_pulse(wr_pulse),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .rd_pulse(rd_pulse),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err),
      .wr_err(wr_err)
   );

   assign oper_mode = ctrl[`TICS_CTRL_OPER];
   assign stamp_fifo_on = ctrl[`TICS_CTRL_FIFO_ON];
   assign stamp_fifo_warn_enable = tx_interrupt_enable[`TICS_BIT_WARN];
   assign stamp_fifo_update_enable = tx_interrupt_enable[`TICS_BIT_UPDATE];
   assign stamp_fifo_warn_flag = tx_interrupt_status[`TICS_BIT_WARN];
   assign stamp_fifo_update_flag = tx_interrupt_status[`TICS_BIT_UPDATE];

   // per-queue enable and sent flag views
   assign queue0_sent_enable = tx_interrupt_enable[`TICS_QUEUE_LSB];
   assign queue1_sent_enable = tx_interrupt_enable[`TICS_QUEUE_LSB + 1];
   assign queue2_sent_enable = tx_interrupt_enable[`TICS_QUEUE_LSB + 2];
   assign queue3_sent_enable = tx_interrupt_enable[`TICS_QUEUE_LSB + 3];
   assign queue0_sent_flag = tx_interrupt_status[`TICS_QUEUE_LSB];
   assign queue1_sent_flag = tx_interrupt_status[`TICS_QUEUE_LSB + 1];
   assign queue2_sent_flag = tx_interrupt_status[`TICS_QUEUE_LSB + 2];
   assign queue3_sent_flag = tx_interrupt_status[`TICS_QUEUE_LSB + 3];

   ////////////////////////////////////////////////////////////////////////////
   // enable and control registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         tx_interrupt_enable <= `TICS_RESET_VALUE;
         ctrl <= `TICS_RESET_VALUE;
         oper_prev <= 1'b0;
      end else begin
         oper_prev <= oper_mode;
         if (wr_pulse && wr_addr == `TICS_ADDR_ENABLE) begin
            tx_interrupt_enable <= (tx_interrupt_enable & ~byte_mask(wr_strb)) |
               (wr_data & byte_mask(wr_strb) & `TICS_FIELD_MASK);
         end
         if (wr_pulse && lane_hit(wr_addr, `TICS_ADDR_CTRL, wr_strb, 5'd0)) begin
            ctrl <= wr_data & `TICS_CTRL_MASK;
         end
      end
   end

   always @* begin
      stamp_fifo_release = wr_pulse && lane_hit(wr_addr, `TICS_ADDR_FIFO_RELEASE, wr_strb, 5'd0) &&
         wr_data[0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // status flags: hardware set wins over software clear
   always @* begin
      next_status = tx_interrupt_status;
      if (wr_pulse) begin
         next_status = next_status & (wr_data | ~{{22{1'b0}},
            {2{lane_hit(wr_addr, `TICS_ADDR_STATUS, wr_strb, 5'd8)}}, {4{1'b0}},
            {4{lane_hit(wr_addr, `TICS_ADDR_STATUS, wr_strb, 5'd0)}}});
      end
      if (!oper_mode || !stamp_fifo_on) begin
         next_status[`TICS_BIT_WARN] = 1'b0;
         next_status[`TICS_BIT_UPDATE] = 1'b0;
      end else begin
         if (stamp_fifo_release) begin
            next_status[`TICS_BIT_UPDATE] = 1'b0;
         end
         if (stamp_frame_done && stamp_fifo_one_entry) begin
            next_status[`TICS_BIT_WARN] = 1'b1;
         end
         if (stamp_frame_done) begin
            next_status[`TICS_BIT_UPDATE] = 1'b1;
         end
      end
      if (oper_prev && !oper_mode) begin
         next_status[3:0] = 4'h0;
      end else if (oper_mode) begin
         next_status[3:0] = next_status[3:0] | queue_frame_sent;
      end
      next_status = next_status & `TICS_FIELD_MASK;
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         tx_interrupt_status <= `TICS_RESET_VALUE;
      end else begin
         tx_interrupt_status <= next_status;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt output
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi = gi + 1) begin : g_src
         assign irq_src[gi] = tx_interrupt_status[gi] & tx_interrupt_enable[gi];
      end
   endgenerate

   always @(posedge aclk) begin
      if (!aresetn) begin
         tx_irq <= 1'b0;
      end else begin
         tx_irq <= (stamp_fifo_warn_flag & stamp_fifo_warn_enable) |
            (stamp_fifo_update_flag & stamp_fifo_update_enable) |
            (queue0_sent_flag & queue0_sent_enable) |
            (queue1_sent_flag & queue1_sent_enable) |
            (queue2_sent_flag & queue2_sent_enable) |
            (queue3_sent_flag & queue3_sent_enable) |
            (|irq_src);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   always @* begin
      rd_err = !is_mapped(rd_addr);
      wr_err = !is_mapped(wr_addr);
      case (rd_addr)
         `TICS_ADDR_ENABLE: rd_data = tx_interrupt_enable & `TICS_FIELD_MASK;
         `TICS_ADDR_STATUS: rd_data = tx_interrupt_status;
         `TICS_ADDR_CTRL: rd_data = ctrl;
         default: rd_data = 32'h00000000;
      endcase
   end

endmodule // tics_top
`default_nettype wire

// *** test/tics_checker_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "tics_defines.vh"
module tics_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic stamp_frame_done,
   input wire logic [3:0] queue_frame_sent,
   input wire logic tx_irq
);
   // cycles since the last hardware event and the last write, saturating
   logic [2:0] since_evt;
   logic [2:0] since_wr;
   logic [3:0] last_ar;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         since_evt <= 3'h7;
         since_wr <= 3'h7;
         last_ar <= 4'h0;
      end else begin
         since_evt <= (stamp_frame_done || (|queue_frame_sent)) ? 3'h0 : (since_evt == 3'h7 ? 3'h7 : since_evt + 3'h1);
         since_wr <= (s_axi_awvalid && s_axi_awready) ? 3'h0 : (since_wr == 3'h7 ? 3'h7 : since_wr + 3'h1);
         if (s_axi_arvalid && s_axi_arready) begin
            last_ar <= s_axi_araddr;
         end
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////
   property p_irq_reset; $rose(aresetn) |-> !tx_irq; endproperty
   a_irq_reset: assert property (p_irq_reset) else $error("irq high right after reset");
   property p_irq_rise; $rose(tx_irq) |-> (since_evt <= 3'h2 || since_wr <= 3'h4); endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq rose without event or write");
   property p_irq_fall; $fell(tx_irq) |-> since_wr <= 3'h4; endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a write");
   property p_rsv_zero;
      s_axi_rvalid && (last_ar == `TICS_ADDR_ENABLE || last_ar == `TICS_ADDR_STATUS)
         |-> (s_axi_rdata & ~`TICS_FIELD_MASK) == 32'h0;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits read nonzero");
   property p_release_zero; s_axi_rvalid && last_ar == `TICS_ADDR_FIFO_RELEASE |-> s_axi_rdata == 32'h0; endproperty
   a_release_zero: assert property (p_release_zero) else $error("release register read nonzero");
   property p_unmapped;
      s_axi_rvalid && last_ar[1:0] != 2'b00 |-> s_axi_rresp == `TICS_RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
   property p_wr_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##3 s_axi_bvalid; endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write response late");
   property p_rd_answer; s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read response late");
endmodule // tics_checker
`default_nettype wire

// *** test/tics_top_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "tics_defines.vh"
module tics_top_bench;
   typedef struct packed {logic wr; logic [3:0] addr; logic [31:0] data; logic [1:0] resp;} tics_row_t;
   localparam int limit = 20000;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_wstrb = 4'hf, s_axi_araddr = 4'h0, queue_frame_sent = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic stamp_frame_done = 1'b0, stamp_fifo_one_entry = 1'b0;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_irq;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   int fails = 0, checks_done = 0, cyc = 0;
   tics_row_t rows [0:7] = '{'{1'b1, `TICS_ADDR_ENABLE, 32'hffffffff, `TICS_RESP_OKAY},
      '{1'b0, `TICS_ADDR_ENABLE, 32'h0000030f, `TICS_RESP_OKAY}, '{1'b0, `TICS_ADDR_STATUS, 32'h0, `TICS_RESP_OKAY},
      '{1'b0, `TICS_ADDR_FIFO_RELEASE, 32'h0, `TICS_RESP_OKAY}, '{1'b1, 4'h2, 32'h1, `TICS_RESP_SLVERR},
      '{1'b0, 4'h6, 32'h0, `TICS_RESP_SLVERR}, '{1'b1, `TICS_ADDR_ENABLE, 32'h0, `TICS_RESP_OKAY},
      '{1'b0, `TICS_ADDR_ENABLE, 32'h0, `TICS_RESP_OKAY}};
   tics_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .stamp_frame_done(stamp_frame_done), .stamp_fifo_one_entry(stamp_fifo_one_entry),
      .queue_frame_sent(queue_frame_sent), .tx_irq(tx_irq));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      logic pa, pw;
      pa = 1'b1;
      pw = 1'b1;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (pa || pw) begin
         @(posedge aclk);
         if (pa && s_axi_awready) begin pa = 1'b0; s_axi_awvalid <= 1'b0; end
         if (pw && s_axi_wready) begin pw = 1'b0; s_axi_wvalid <= 1'b0; end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask
   task automatic axr(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      s_axi_rready <= 1'b0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask
   task automatic evt(input logic [3:0] q, input logic sfd, input logic one);
      @(posedge aclk);
      queue_frame_sent <= q;
      stamp_frame_done <= sfd;
      stamp_fifo_one_entry <= one;
      @(posedge aclk);
      queue_frame_sent <= 4'h0;
      stamp_frame_done <= 1'b0;
   endtask
   task automatic irq(input logic e);
      repeat (3) @(posedge aclk);
      chk("tx_irq", {31'h0, e}, {31'h0, tx_irq});
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      forever #2 aclk = ~aclk;
   end
   initial begin
      forever begin
         @(posedge aclk);
         cyc++;
         if (cyc == limit) begin fails++; end_sim(); end
      end
   end
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      irq(1'b0);
      axr(`TICS_ADDR_ENABLE, 32'h0, `TICS_RESP_OKAY);
      axr(`TICS_ADDR_STATUS, 32'h0, `TICS_RESP_OKAY);
      $display("test reset done");
      foreach (rows[i]) begin
         if (rows[i].wr) axw(rows[i].addr, rows[i].data, rows[i].resp);
         else axr(rows[i].addr, rows[i].data, rows[i].resp);
      end
      $display("test register map done");
      axw(`TICS_ADDR_CTRL, 32'h3, `TICS_RESP_OKAY);
      axw(`TICS_ADDR_ENABLE, 32'h30f, `TICS_RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         evt(4'h1 << i, 1'b0, 1'b0);
         irq(1'b1);
         axr(`TICS_ADDR_STATUS, 32'h1 << i, `TICS_RESP_OKAY);
         axw(`TICS_ADDR_STATUS, ~(32'h1 << i), `TICS_RESP_OKAY);
         axr(`TICS_ADDR_STATUS, 32'h0, `TICS_RESP_OKAY);
         irq(1'b0);
      end
      $display("test queue flags done");
      evt(4'h0, 1'b1, 1'b0);
      irq(1'b1);
      axr(`TICS_ADDR_STATUS, 32'h100, `TICS_RESP_OKAY);
      axw(`TICS_ADDR_FIFO_RELEASE, 32'h1, `TICS_RESP_OKAY);
      axr(`TICS_ADDR_STATUS, 32'h0, `TICS_RESP_OKAY);
      irq(1'b0);
      evt(4'h0, 1'b1, 1'b1);
      irq(1'b1);
      axr(`TICS_ADDR_STATUS, 32'h300, `TICS_RESP_OKAY);
      axw(`TICS_ADDR_STATUS, 32'h3ff, `TICS_RESP_OKAY);
      axr(`TICS_ADDR_STATUS, 32'h300, `TICS_RESP_OKAY);
      axw(`TICS_ADDR_FIFO_RELEASE, 32'h1, `TICS_RESP_OKAY);
      axr(`TICS_ADDR_STATUS, 32'h200, `TICS_RESP_OKAY);
      irq(1'b1);
      axw(`TICS_ADDR_CTRL, 32'h2, `TICS_RESP_OKAY);
      axr(`TICS_ADDR_STATUS, 32'h0, `TICS_RESP_OKAY);
      irq(1'b0);
      $display("test stamp flags done");
      axw(`TICS_ADDR_CTRL, 32'h3, `TICS_RESP_OKAY);
      axw(`TICS_ADDR_ENABLE, 32'h0, `TICS_RESP_OKAY);
      evt(4'h1, 1'b0, 1'b0);
      irq(1'b0);
      axr(`TICS_ADDR_STATUS, 32'h1, `TICS_RESP_OKAY);
      axw(`TICS_ADDR_ENABLE, 32'h1, `TICS_RESP_OKAY);
      irq(1'b1);
      axw(`TICS_ADDR_CTRL, 32'h0, `TICS_RESP_OKAY);
      axr(`TICS_ADDR_STATUS, 32'h0, `TICS_RESP_OKAY);
      irq(1'b0);
      $display("test masking done");
      axw(`TICS_ADDR_CTRL, 32'h3, `TICS_RESP_OKAY);
      evt(4'h0, 1'b1, 1'b1);
      axw(`TICS_ADDR_STATUS, 32'hfffffcff, `TICS_RESP_OKAY);
      axr(`TICS_ADDR_STATUS, 32'h0, `TICS_RESP_OKAY);
      evt(4'h0, 1'b1, 1'b1);
      axw(`TICS_ADDR_CTRL, 32'h1, `TICS_RESP_OKAY);
      axr(`TICS_ADDR_STATUS, 32'h0, `TICS_RESP_OKAY);
      s_axi_wstrb <= 4'h1;
      axw(`TICS_ADDR_ENABLE, 32'h30f, `TICS_RESP_OKAY);
      axr(`TICS_ADDR_ENABLE, 32'h00f, `TICS_RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      axw(`TICS_ADDR_CTRL, 32'h3, `TICS_RESP_OKAY);
      axw(`TICS_ADDR_ENABLE, 32'h30f, `TICS_RESP_OKAY);
      evt(4'hf, 1'b1, 1'b1);
      irq(1'b1);
      aresetn <= 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      irq(1'b0);
      axr(`TICS_ADDR_ENABLE, 32'h0, `TICS_RESP_OKAY);
      axr(`TICS_ADDR_STATUS, 32'h0, `TICS_RESP_OKAY);
      axr(`TICS_ADDR_CTRL, 32'h0, `TICS_RESP_OKAY);
      $display("test awkward cases done");
      end_sim();
   end
endmodule // tics_top_bench
bind tics_top tics_checker i_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .stamp_frame_done(stamp_frame_done), .queue_frame_sent(queue_frame_sent), .tx_irq(tx_irq));
`default_nettype wire
